// file: pkg/kgd_pkg.sv
// Constants, register map and state types of the keypad and pin interrupt block
package kgd_pkg;

	// Timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int MS_PERIOD_PS = 1000000000;
	localparam int MS_TICK_CYCLES = MS_PERIOD_PS / CLK_PERIOD_PS;

	// Sizes
	localparam int PIN_COUNT = 32;
	localparam int PIN_SEL_W = 5;
	localparam int PIN_IRQ_COUNT = 5;
	localparam int DEB_W = 6;

	// Register byte offsets
	localparam logic [7:0] KEYPAD_PIN_INCLUDE_OFS = 8'h00;
	localparam logic [7:0] KEYPAD_INPUT_CONFIG_OFS = 8'h04;
	localparam logic [7:0] DEBOUNCE_CONFIG_OFS = 8'h08;
	localparam logic [7:0] PIN_IRQ_MODE_OFS = 8'h0C;
	localparam logic [7:0] PIN_IRQ_SOURCE_SELECT_0_OFS = 8'h10;
	localparam logic [7:0] PIN_IRQ_FLAG_OFS = 8'h24;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h28;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h2C;
	localparam logic [7:0] PORT_PIN_STATE_OFS = 8'h30;
	localparam logic [7:0] SOURCE_SELECT_STRIDE = 8'h04;

	// Field positions of keypad_input_config
	localparam int KEY_REPEAT_LSB = 0;
	localparam int KEYPAD_POLARITY_BIT = 6;
	localparam int KEYPAD_RELEASE_BIT = 7;

	// Field positions of the debounce configuration
	localparam int DEBOUNCE_INTERVAL_LSB = 0;
	localparam int KEYPAD_DEB_EN_BIT = 6;
	localparam int PIN_DEB_EN_LSB = 7;

	// Field positions of the pin interrupt mode register
	localparam int PIN_POLARITY_LSB = 0;
	localparam int PIN_EDGE_MODE_LSB = 8;

	// Status and mask layout
	localparam int STATUS_KEYPAD_BIT = 0;
	localparam int STATUS_PIN_LSB = 1;
	localparam int STATUS_W = 6;

	// Reset values
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [DEB_W-1:0] TIMER_RESET = 6'h00;

	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ = 2'b11;

	typedef enum logic [1:0] {
		KP_IDLE = 2'b00,
		KP_PRESS_DEB = 2'b01,
		KP_HELD = 2'b11,
		KP_RELEASE_DEB = 2'b10
	} kgd_keypad_state_e;

	typedef enum logic [1:0] {
		PI_IDLE = 2'b00,
		PI_DEBOUNCE = 2'b01,
		PI_FLAGGED = 2'b11,
		PI_WAIT_RELEASE = 2'b10
	} kgd_pin_state_e;

endpackage : kgd_pkg

// file: rtl/kgd_ms_tick.sv
// Divider that gives a one-cycle pulse every millisecond
`timescale 1ns/1ps
module kgd_ms_tick import kgd_pkg::*; #(
	parameter int unsigned CYCLES = MS_TICK_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	output logic tick_o
);

	logic [31:0] count_reg;

	// Counts CYCLES clocks per pulse
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			count_reg <= 32'h0000_0000;
			tick_o <= 1'b0;
		end else if (count_reg == CYCLES - 32'd1) begin
			count_reg <= 32'h0000_0000;
			tick_o <= 1'b1; // R5
		end else begin
			count_reg <= count_reg + 32'd1;
			tick_o <= 1'b0;
		end
	end

endmodule : kgd_ms_tick

// file: rtl/kgd_pin_irq.sv
// One pin interrupt generator with debounce, level or edge mode and wait-for-release
`timescale 1ns/1ps
module kgd_pin_irq import kgd_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic tick_i,
	input wire logic pin_i,
	input wire logic polarity_i,
	input wire logic edge_mode_i,
	input wire logic debounce_enable_i,
	input wire logic [DEB_W-1:0] debounce_interval_i,
	input wire logic clear_i,
	output logic flag_o,
	output logic event_o
);

	kgd_pin_state_e state_reg;
	logic hit;
	logic hit_prev_reg;
	logic [DEB_W-1:0] timer_reg;
	logic start;
	logic expire;

	assign hit = pin_i ^ polarity_i; // R11 R17
	assign start = edge_mode_i ? (hit && !hit_prev_reg) : hit;
	assign expire = (timer_reg == TIMER_RESET); // R12 R18

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			hit_prev_reg <= 1'b0;
		end else begin
			hit_prev_reg <= hit;
		end
	end

	// Debounce timer, loaded on activation and counted down each millisecond
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			timer_reg <= TIMER_RESET;
		end else if (state_reg == PI_IDLE && start) begin
			timer_reg <= debounce_enable_i ? debounce_interval_i : TIMER_RESET; // R4 R12
		end else if (state_reg == PI_DEBOUNCE && tick_i && !expire) begin
			timer_reg <= timer_reg - 6'h01; // R5
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= PI_IDLE;
			flag_o <= 1'b0;
			event_o <= 1'b0;
		end else begin
			event_o <= 1'b0;
			case (state_reg)
				PI_IDLE: begin
					if (start) begin
						state_reg <= PI_DEBOUNCE; // R11
					end
				end
				PI_DEBOUNCE: begin
					if (!hit) begin
						state_reg <= PI_IDLE;
					end else if (expire) begin
						flag_o <= 1'b1; // R12
						event_o <= 1'b1;
						state_reg <= PI_FLAGGED;
					end
				end
				PI_FLAGGED: begin
					if (clear_i) begin
						flag_o <= 1'b0; // R13
						state_reg <= edge_mode_i ? PI_WAIT_RELEASE : PI_IDLE; // R14
					end
				end
				PI_WAIT_RELEASE: begin
					if (!hit) begin
						state_reg <= PI_IDLE; // R14 R15
					end
				end
				default: begin
					state_reg <= PI_IDLE;
				end
			endcase
		end
	end

endmodule : kgd_pin_irq

// file: rtl/kgd_top.sv
// Keypad scanner, five pin interrupt generators and their AHB-Lite register file
//
// How it works
// R1: One keypad interrupt and five pin interrupts, each from selectable pin changes.
// R2: Only pins whose keypad include bit is one take part in keypad scanning.
// R3: Polarity zero: a high-to-low change on an included pin starts the keypad machine.
// R4: Each activation loads the debounce timer with the six-bit interval, 0 to 63 ms.
// R5: The debounce timer counts down once per millisecond.
// R6: On expiry with key still down, interrupt and reload timer with repeat value.
// R7: A repeat value of zero gives one interrupt per press, no auto-repeat.
// R8: With release enable set, release is debounced and then interrupts.
// R9: Keypad debounce enable at zero skips the debounce delay.
// R10: Each pin generator watches one pin chosen by its own source select register.
// R11: Pin polarity zero: a low-to-high change starts that generator's machine.
// R12: Pin generator interrupts when its timer expires with pin still active; own bypass.
// R13: A pin interrupt flag holds until software writes its clear bit.
// R14: In edge mode a clear goes to wait-for-release, idle after inactive edge.
// R15: Software flips pin polarity while waiting for release to catch both edges.
// R16: Software reads the pin state register to find the pressed key.
// R17: Polarity bit at one makes the opposite transition the active one.
// R18: Interval field is six bits; zero expires at once.
`timescale 1ns/1ps
module kgd_top import kgd_pkg::*; #(
	parameter int unsigned MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [PIN_COUNT-1:0] port_pin_state_i,
	output logic keypad_interrupt_o,
	output logic [PIN_IRQ_COUNT-1:0] pin_interrupt_o,
	output logic irq_o
);

	// Registers
	logic [31:0] keypad_pin_include_bits_reg;
	logic [31:0] keypad_input_config_reg;
	logic [31:0] debounce_config_reg;
	logic [31:0] pin_irq_mode_reg;
	logic [PIN_SEL_W-1:0] pin_irq_source_select_reg [PIN_IRQ_COUNT];
	logic [STATUS_W-1:0] irq_status_reg;
	logic [STATUS_W-1:0] irq_status_next;
	logic [STATUS_W-1:0] irq_mask_reg;

	// Bus pipeline
	logic wr_pending_reg;
	logic [7:0] wr_addr_reg;
	logic rd_accept;
	logic wr_accept;
	logic [31:0] rd_value;
	logic status_read;

	// Fields
	logic [DEB_W-1:0] key_repeat;
	logic keypad_polarity_select;
	logic keypad_release_irq_enable;
	logic [DEB_W-1:0] debounce_interval;
	logic keypad_debounce_enable;
	logic [PIN_IRQ_COUNT-1:0] pin_irq_debounce_enable;
	logic [PIN_IRQ_COUNT-1:0] pin_irq_polarity;
	logic [PIN_IRQ_COUNT-1:0] pin_irq_edge_mode;
	logic [PIN_IRQ_COUNT-1:0] pin_clear;
	logic [PIN_IRQ_COUNT-1:0] pin_event;

	// Keypad scanner
	kgd_keypad_state_e kp_state_reg;
	logic [DEB_W-1:0] kp_timer_reg;
	logic kp_hit;
	logic kp_hit_prev_reg;
	logic kp_expire;
	logic kp_event;
	logic ms_tick;

	assign key_repeat = keypad_input_config_reg[KEY_REPEAT_LSB +: DEB_W];
	assign keypad_polarity_select = keypad_input_config_reg[KEYPAD_POLARITY_BIT];
	assign keypad_release_irq_enable = keypad_input_config_reg[KEYPAD_RELEASE_BIT];
	assign debounce_interval = debounce_config_reg[DEBOUNCE_INTERVAL_LSB +: DEB_W];
	assign keypad_debounce_enable = debounce_config_reg[KEYPAD_DEB_EN_BIT];
	assign pin_irq_debounce_enable = debounce_config_reg[PIN_DEB_EN_LSB +: PIN_IRQ_COUNT];
	assign pin_irq_polarity = pin_irq_mode_reg[PIN_POLARITY_LSB +: PIN_IRQ_COUNT];
	assign pin_irq_edge_mode = pin_irq_mode_reg[PIN_EDGE_MODE_LSB +: PIN_IRQ_COUNT];

	kgd_ms_tick #(
		.CYCLES(MS_TICK_CYCLES_P)
	) u_ms_tick (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.tick_o(ms_tick)
	);

	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign rd_accept = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
	assign wr_accept = hsel_i && hready_i && htrans_i[1] && hwrite_i;
	assign status_read = rd_accept && (haddr_i[7:0] == IRQ_STATUS_OFS);

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			wr_pending_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else if (hready_i) begin
			wr_pending_reg <= wr_accept;
			wr_addr_reg <= haddr_i[7:0];
		end
	end

	// Read mux, sampled in the address phase so data stands from a flop
	always_comb begin
		rd_value = 32'h0000_0000;
		case (haddr_i[7:0])
			KEYPAD_PIN_INCLUDE_OFS: rd_value = keypad_pin_include_bits_reg;
			KEYPAD_INPUT_CONFIG_OFS: rd_value = keypad_input_config_reg;
			DEBOUNCE_CONFIG_OFS: rd_value = debounce_config_reg;
			PIN_IRQ_MODE_OFS: rd_value = pin_irq_mode_reg;
			PIN_IRQ_FLAG_OFS: rd_value = {27'h0000000, pin_interrupt_o};
			IRQ_STATUS_OFS: rd_value = {26'h0000000, irq_status_reg};
			IRQ_MASK_OFS: rd_value = {26'h0000000, irq_mask_reg};
			PORT_PIN_STATE_OFS: rd_value = port_pin_state_i; // R16
			default: begin
				for (int i = 0; i < PIN_IRQ_COUNT; i++) begin
					if (haddr_i[7:0] == PIN_IRQ_SOURCE_SELECT_0_OFS
							+ 8'(i) * SOURCE_SELECT_STRIDE) begin
						rd_value = {27'h0000000, pin_irq_source_select_reg[i]};
					end
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			hrdata_o <= 32'h0000_0000;
		end else if (rd_accept) begin
			hrdata_o <= rd_value;
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			keypad_pin_include_bits_reg <= REG_RESET;
			keypad_input_config_reg <= REG_RESET;
			debounce_config_reg <= REG_RESET;
			pin_irq_mode_reg <= REG_RESET;
			irq_mask_reg <= REG_RESET[STATUS_W-1:0];
			for (int i = 0; i < PIN_IRQ_COUNT; i++) begin
				pin_irq_source_select_reg[i] <= REG_RESET[PIN_SEL_W-1:0];
			end
		end else if (wr_pending_reg) begin
			case (wr_addr_reg)
				KEYPAD_PIN_INCLUDE_OFS: keypad_pin_include_bits_reg <= hwdata_i; // R2
				KEYPAD_INPUT_CONFIG_OFS: keypad_input_config_reg <= {24'h000000, hwdata_i[7:0]};
				DEBOUNCE_CONFIG_OFS: debounce_config_reg <= {20'h00000, hwdata_i[11:0]};
				PIN_IRQ_MODE_OFS: pin_irq_mode_reg <= {19'h00000, hwdata_i[12:8], 3'h0,
					hwdata_i[4:0]};
				IRQ_MASK_OFS: irq_mask_reg <= hwdata_i[STATUS_W-1:0];
				default: begin
					for (int i = 0; i < PIN_IRQ_COUNT; i++) begin
						if (wr_addr_reg == PIN_IRQ_SOURCE_SELECT_0_OFS
								+ 8'(i) * SOURCE_SELECT_STRIDE) begin
							pin_irq_source_select_reg[i] <= hwdata_i[PIN_SEL_W-1:0]; // R10
						end
					end
				end
			endcase
		end
	end

	// Writing a one to a flag bit clears that pin interrupt
	assign pin_clear = (wr_pending_reg && wr_addr_reg == PIN_IRQ_FLAG_OFS)
		? hwdata_i[PIN_IRQ_COUNT-1:0] : 5'h00; // R13

	// Sticky status, cleared by its own read; a new event wins over the clear
	always_comb begin
		irq_status_next = irq_status_reg;
		if (status_read) begin
			irq_status_next = 6'h00;
		end
		irq_status_next[STATUS_KEYPAD_BIT] = irq_status_next[STATUS_KEYPAD_BIT] | kp_event;
		irq_status_next[STATUS_PIN_LSB +: PIN_IRQ_COUNT] =
			irq_status_next[STATUS_PIN_LSB +: PIN_IRQ_COUNT] | pin_event;
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			irq_status_reg <= 6'h00;
			irq_o <= 1'b0;
		end else begin
			irq_status_reg <= irq_status_next;
			irq_o <= |(irq_status_next & irq_mask_reg);
		end
	end

	// Pin interrupt generators
	for (genvar g = 0; g < PIN_IRQ_COUNT; g++) begin : g_pin_irq
		kgd_pin_irq u_pin_irq (
			.ref_clk_i(ref_clk_i),
			.sys_rst_i(sys_rst_i),
			.tick_i(ms_tick),
			.pin_i(port_pin_state_i[pin_irq_source_select_reg[g]]), // R10
			.polarity_i(pin_irq_polarity[g]), // R17
			.edge_mode_i(pin_irq_edge_mode[g]),
			.debounce_enable_i(pin_irq_debounce_enable[g]),
			.debounce_interval_i(debounce_interval),
			.clear_i(pin_clear[g]),
			.flag_o(pin_interrupt_o[g]), // R1
			.event_o(pin_event[g])
		);
	end

	// Keypad scanner: active pins are low unless polarity is set
	assign kp_hit = |(keypad_pin_include_bits_reg
		& (keypad_polarity_select ? port_pin_state_i : ~port_pin_state_i)); // R2 R3 R17
	assign kp_expire = (kp_timer_reg == TIMER_RESET); // R18

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			kp_hit_prev_reg <= 1'b0;
		end else begin
			kp_hit_prev_reg <= kp_hit;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			kp_state_reg <= KP_IDLE;
			kp_timer_reg <= TIMER_RESET;
			kp_event <= 1'b0;
		end else begin
			kp_event <= 1'b0;
			case (kp_state_reg)
				KP_IDLE: begin
					if (kp_hit && !kp_hit_prev_reg) begin
						kp_timer_reg <= keypad_debounce_enable ? debounce_interval
							: TIMER_RESET; // R3 R4 R9
						kp_state_reg <= KP_PRESS_DEB;
					end
				end
				KP_PRESS_DEB: begin
					if (!kp_hit) begin
						kp_state_reg <= KP_IDLE;
					end else if (kp_expire) begin
						kp_event <= 1'b1; // R6
						kp_timer_reg <= key_repeat; // R6
						kp_state_reg <= KP_HELD;
					end else if (ms_tick) begin
						kp_timer_reg <= kp_timer_reg - 6'h01; // R5
					end
				end
				KP_HELD: begin
					if (!kp_hit) begin
						if (keypad_release_irq_enable) begin
							kp_timer_reg <= keypad_debounce_enable ? debounce_interval
								: TIMER_RESET; // R8 R9
							kp_state_reg <= KP_RELEASE_DEB;
						end else begin
							kp_state_reg <= KP_IDLE; // R8
						end
					end else if (key_repeat != TIMER_RESET) begin // R7
						if (kp_expire) begin
							kp_event <= 1'b1; // R6
							kp_timer_reg <= key_repeat;
						end else if (ms_tick) begin
							kp_timer_reg <= kp_timer_reg - 6'h01; // R5
						end
					end
				end
				KP_RELEASE_DEB: begin
					if (kp_hit) begin
						kp_timer_reg <= key_repeat;
						kp_state_reg <= KP_HELD;
					end else if (kp_expire) begin
						kp_event <= 1'b1; // R8
						kp_state_reg <= KP_IDLE;
					end else if (ms_tick) begin
						kp_timer_reg <= kp_timer_reg - 6'h01; // R5
					end
				end
				default: begin
					kp_state_reg <= KP_IDLE;
				end
			endcase
		end
	end

	// One-cycle keypad interrupt pulse per debounced press, repeat or release
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			keypad_interrupt_o <= 1'b0;
		end else begin
			keypad_interrupt_o <= kp_event; // R1
		end
	end

endmodule : kgd_top

// file: test/kgd_keys.sv
// Key and pin model with optional contact bounce
`timescale 1ns/1ps
module kgd_keys (
	input wire logic ref_clk_i,
	input wire logic [31:0] want_i,
	input wire logic bounce_i,
	output logic [31:0] pins_o
);
	logic [31:0] last_reg = '1;
	logic [2:0] cnt_reg = 3'h0;
	always_ff @(posedge ref_clk_i) begin
		if (want_i == last_reg || !bounce_i || cnt_reg == 3'h5) begin
			last_reg <= want_i;
			cnt_reg <= 3'h0;
		end else begin
			cnt_reg <= cnt_reg + 3'h1;
		end
	end
	// Bouncing contacts alternate between old and new level
	assign pins_o = (cnt_reg[0] || want_i == last_reg) ? last_reg : want_i;
endmodule : kgd_keys

// file: test/kgd_chk.sv
// Port checks of the keypad and pin interrupt block
`timescale 1ns/1ps
module kgd_chk import kgd_pkg::*; #(
	parameter int unsigned MS_TICK_CYCLES_P = MS_TICK_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic [PIN_COUNT-1:0] port_pin_state_i,
	input wire logic keypad_interrupt_o,
	input wire logic [PIN_IRQ_COUNT-1:0] pin_interrupt_o,
	input wire logic irq_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic wr_dp;
	logic [4:0] clr_q;
	logic [4:0] clr_q2;
	logic [4:0] prev_q;
	wire logic rd_ap = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
	always_ff @(posedge ref_clk_i) begin
		wr_dp <= hsel_i && hready_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == PIN_IRQ_FLAG_OFS;
		clr_q <= wr_dp ? hwdata_i[4:0] : 5'h00;
		clr_q2 <= clr_q;
		prev_q <= pin_interrupt_o;
	end
	sequence s_rd(logic [7:0] a);
		rd_ap && haddr_i[7:0] == a;
	endsequence
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus not ready or not okay");
	a_flag_hold: assert property ((~pin_interrupt_o & prev_q & ~(clr_q | clr_q2)) == 5'h00)
		else $error("pin flag dropped without clear");
	a_kp_pulse: assert property (keypad_interrupt_o |=> !keypad_interrupt_o)
		else $error("keypad interrupt longer than one cycle");
	a_reset_quiet: assert property ($fell(sys_rst_i)
		|-> !irq_o && !keypad_interrupt_o && pin_interrupt_o == 5'h00)
		else $error("outputs active after reset");
	a_pin_read: assert property (s_rd(PORT_PIN_STATE_OFS)
		|=> hrdata_o == $past(port_pin_state_i))
		else $error("pin state read wrong");
	a_flag_read: assert property (s_rd(PIN_IRQ_FLAG_OFS)
		|=> hrdata_o == {27'h0, $past(pin_interrupt_o)})
		else $error("pin flag read wrong");
	a_unmapped_zero: assert property (s_rd(8'h40) |=> hrdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_rdata_stands: assert property (!rd_ap |=> $stable(hrdata_o))
		else $error("read data changed without read");
endmodule : kgd_chk
bind kgd_top kgd_chk #(.MS_TICK_CYCLES_P(MS_TICK_CYCLES_P)) kgd_chk_inst (.ref_clk_i, .sys_rst_i,
	.hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
	.hresp_o, .port_pin_state_i, .keypad_interrupt_o, .pin_interrupt_o, .irq_o);

// file: test/tb.sv
// Self-checking bench of the keypad and pin interrupt block
`timescale 1ns/1ps
module tb;
	import kgd_pkg::*;
	localparam int T = 10;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = '0;
	logic [1:0] htrans_i = 2'b00;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = '0;
	logic [31:0] hrdata_o;
	logic hready_i, hreadyout_o, hresp_o, keypad_interrupt_o, irq_o;
	logic [4:0] pin_interrupt_o;
	logic [31:0] port_pin_state_i;
	// Pins start low so no generator fires before the reset reads
	logic [31:0] want = '0;
	logic bounce = 1'b0;
	logic [31:0] rnd = 32'hDC16;
	logic [31:0] q;
	logic [4:0] p [5];
	int n_errors = 0;
	int tests_run = 0;
	int kp_n = 0;
	int k;
	assign hready_i = hreadyout_o;
	always #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (keypad_interrupt_o === 1'b1) kp_n++;
	kgd_top #(.MS_TICK_CYCLES_P(T)) kgd_top_inst (.ref_clk_i, .sys_rst_i, .hsel_i, .haddr_i,
		.htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
		.hresp_o, .port_pin_state_i, .keypad_interrupt_o, .pin_interrupt_o, .irq_o);
	kgd_keys kgd_keys_inst (.ref_clk_i, .want_i(want), .bounce_i(bounce), .pins_o(port_pin_state_i));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// Longest wait for a debounced event of ms milliseconds
	function automatic int deb(input int ms);
		return (ms + 2) * T + 6;
	endfunction : deb
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= HTRANS_NONSEQ;
		hwrite_i <= w;
		haddr_i <= {24'h0, a};
		do @(posedge ref_clk_i); while (hready_i !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		do @(posedge ref_clk_i); while (hready_i !== 1'b1);
		q = hrdata_o;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : idle
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_errors++;
		end_sim();
	end
	initial begin
		repeat (6) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		for (int a = 0; a < 'h30; a += 4) begin
			rd(8'(a));
			chk("reset word", 32'h0, q);
		end
		rnd = lfsr(rnd);
		wr(KEYPAD_PIN_INCLUDE_OFS, rnd);
		rd(KEYPAD_PIN_INCLUDE_OFS);
		chk("include bits", rnd, q);
		wr(8'h40, rnd);
		rd(8'h40);
		chk("unmapped", 32'h0, q);
		want <= rnd;
		idle(2);
		rd(PORT_PIN_STATE_OFS);
		chk("pin state", rnd, q);
		k = rnd[4:0];
		want <= '1;
		wr(DEBOUNCE_CONFIG_OFS, 32'h42);
		wr(KEYPAD_INPUT_CONFIG_OFS, 32'h80);
		wr(KEYPAD_PIN_INCLUDE_OFS, 32'h1 << k);
		bounce <= 1'b1;
		kp_n = 0;
		want[k ^ 1] <= 1'b0;
		idle(deb(2));
		chk("excluded pin", 0, kp_n);
		want[k] <= 1'b0;
		idle(8);
		chk("early", 0, kp_n);
		idle(deb(2));
		chk("press", 1, kp_n);
		want <= '1;
		idle(deb(2));
		chk("release", 2, kp_n);
		wr(KEYPAD_INPUT_CONFIG_OFS, 32'h03);
		kp_n = 0;
		want[k] <= 1'b0;
		idle(300);
		want[k] <= 1'b1;
		idle(deb(2));
		chk("repeats", 1, kp_n >= 300 / (4 * T) && kp_n <= 300 / (3 * T) + 2);
		wr(DEBOUNCE_CONFIG_OFS, 32'h3F);
		rd(IRQ_STATUS_OFS);
		kp_n = 0;
		wr(KEYPAD_INPUT_CONFIG_OFS, 32'h40);
		idle(6);
		chk("no debounce", 1, kp_n);
		rd(IRQ_STATUS_OFS);
		chk("keypad status", 1, q[0]);
		bounce <= 1'b0;
		want <= '0;
		wr(DEBOUNCE_CONFIG_OFS, 32'hF81);
		for (int g = 0; g < 5; g++) begin
			p[g] = rnd[4:0] + 5'(6 * g);
			wr(PIN_IRQ_SOURCE_SELECT_0_OFS + 8'(4 * g), {27'h0, p[g]});
		end
		// Flags raised while pin 0 was high earlier are cleared before the loop
		wr(PIN_IRQ_FLAG_OFS, 32'h1F);
		idle(1);
		chk("all cleared", 0, pin_interrupt_o);
		for (int g = 0; g < 5; g++) begin
			rd(IRQ_STATUS_OFS);
			wr(IRQ_MASK_OFS, 32'h2 << g);
			want <= 32'h1 << p[g];
			idle(deb(1));
			chk("pin flag", 1, pin_interrupt_o[g]);
			chk("irq", 1, irq_o);
			rd(IRQ_STATUS_OFS);
			chk("status", 32'h2 << g, q & 32'h3E);
			idle(2);
			chk("irq cleared", 0, irq_o);
			wr(PIN_IRQ_FLAG_OFS, 32'h1 << g);
			#1;
			chk("flag cleared", 0, pin_interrupt_o[g]);
			idle(deb(1));
			chk("level refire", 1, pin_interrupt_o[g]);
		end
		want <= 32'h1 << p[0];
		wr(PIN_IRQ_MODE_OFS, 32'h100);
		wr(PIN_IRQ_FLAG_OFS, 32'h1);
		idle(deb(1));
		chk("edge wait", 0, pin_interrupt_o[0]);
		wr(PIN_IRQ_MODE_OFS, 32'h101);
		idle(3);
		want <= '0;
		idle(deb(1));
		chk("other edge", 1, pin_interrupt_o[0]);
		end_sim();
	end
endmodule : tb
